// file: rtl/ubt_regs.svh
/*
 * register offsets, field positions and reset values of the baud rate
 * generator and receive idle time-out block.
 * assumes byte addresses on a 32-bit bus, one aligned word per register.
 */
`ifndef UBT_REGS_SVH
`define UBT_REGS_SVH

// ==========================================================
// offsets
`define UBT_OFS_TOR 8'h20
`define UBT_OFS_BAUD 8'h24
`define UBT_OFS_ISR 8'h40
`define UBT_OFS_IMR 8'h44
`define UBT_OFS_CTL 8'h48

// ==========================================================
// reset values and writable masks
`define UBT_RST_TOR 32'h00000000
`define UBT_RST_BAUD 32'h0F000000
`define UBT_RST_CTL 32'h00000000
`define UBT_MSK_TOR 32'h0000FFFF
`define UBT_MSK_BAUD 32'h3F00FFFF
`define UBT_MSK_CTL 32'h00000310

// ==========================================================
// fields
`define UBT_TOR_CMP 7:0
`define UBT_TOR_GAP 15:8
`define UBT_BAUD_DIV 15:0
`define UBT_BAUD_X 27:24
`define UBT_BAUD_ONE 28
`define UBT_BAUD_XEN 29
`define UBT_CTL_IEN 4
`define UBT_CTL_FSEL 9:8
`define UBT_FSEL_IR 2'b10
`define UBT_EVT_IDLE 0
`define UBT_EVT_GAP 1
`define UBT_M16_LAST 4'hF
`define UBT_SIZE_WORD 3'h2
`define UBT_ADDR_LSB 7:0

`endif

// file: rtl/ubt_pkg.sv
/*
 * types shared by the baud and idle time-out block.
 * assumes ubt_regs.svh for all numeric constants except the gap state encodings.
 */
package ubt_pkg;

	// ==========================================================
	// gap sequencer
	typedef enum logic [1:0] {
		ubt_gap_idle = 2'b01,
		ubt_gap_wait = 2'b10
	} ubt_gap_e;

	// ==========================================================
	// state records
	typedef struct packed {
		logic [16:0] div_cnt;
		logic [3:0] pre_cnt;
		logic sub_tick;
		logic bit_tick;
	} ubt_baud_s;

	typedef struct packed {
		logic ph_act;
		logic ph_wr;
		logic [7:0] ph_addr;
		logic [31:0] hrdata;
		logic [31:0] tor;
		logic [31:0] baud;
		logic [31:0] ctl;
		logic [1:0] isr;
		logic [1:0] imr;
		logic idle_flag;
		logic idle_irq;
		logic irq;
		ubt_gap_e gap_st;
	} ubt_top_s;

endpackage

// file: rtl/ubt_tick_cnt.sv
/*
 * saturating event counter with synchronous clear.
 * assumes clr and inc come from logic on hclk.
 */
module ubt_tick_cnt
	import ubt_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clr,
	input wire logic inc,
	output logic [W-1:0] cnt
);

	typedef struct packed {
		logic [W-1:0] cnt;
	} ubt_cnt_s;

	ubt_cnt_s st_ff;
	ubt_cnt_s nxt_st;

	// ==========================================================
	// counter
	// saturating so a long silence cannot wrap back onto the compare value
	always_comb begin
		nxt_st = st_ff;
		if (clr) begin
			nxt_st.cnt = '0;
		end else if (inc && (st_ff.cnt != {W{1'b1}})) begin
			nxt_st.cnt = st_ff.cnt + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign cnt = st_ff.cnt;

endmodule

// file: rtl/ubt_baud_gen.sv
/*
 * baud generator: divides hclk by (divisor + 2), then by the prescale M.
 * assumes configuration inputs come from registers on hclk.
 */
`include "ubt_regs.svh"

module ubt_baud_gen
	import ubt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [15:0] baud_divisor,
	input wire logic [3:0] prescale_value,
	input wire logic prescale_enable,
	input wire logic prescale_unity,
	input wire logic ir_mode,
	output logic sample_tick,
	output logic bit_tick
);

	ubt_baud_s st_ff;
	ubt_baud_s nxt_st;
	logic [16:0] div_last;
	logic [3:0] m_last;

	// ==========================================================
	// prescale selection
	always_comb begin
		div_last = {1'b0, baud_divisor} + 17'h00001;
		if (prescale_unity) begin
			m_last = 4'h0;
		// prescale forced off in infrared mode
		end else if (prescale_enable && !ir_mode) begin
			m_last = prescale_value;
		end else begin
			m_last = `UBT_M16_LAST;
		end
	end

	// ==========================================================
	// divider chain
	// divisor plus two
	always_comb begin
		nxt_st = st_ff;
		nxt_st.sub_tick = 1'b0;
		nxt_st.bit_tick = 1'b0;
		// compare with >= so a shrinking reprogram never overruns
		if (st_ff.div_cnt >= div_last) begin
			nxt_st.div_cnt = 17'h00000;
			nxt_st.sub_tick = 1'b1;
			if (st_ff.pre_cnt >= m_last) begin
				nxt_st.pre_cnt = 4'h0;
				nxt_st.bit_tick = 1'b1;
			end else begin
				nxt_st.pre_cnt = st_ff.pre_cnt + 4'h1;
			end
		end else begin
			nxt_st.div_cnt = st_ff.div_cnt + 17'h00001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sample_tick = st_ff.sub_tick;
	assign bit_tick = st_ff.bit_tick;

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_div_period: assert property (
		sample_tick && baud_divisor == 16'h0000 ##1 $stable(baud_divisor) |=> sample_tick)
		else $error("sample tick period wrong for divisor zero");
	a_div_gap: assert property (
		sample_tick && $stable(baud_divisor) |=> !sample_tick)
		else $error("sample tick repeated too soon");
	a_unity_m: assert property (
		sample_tick && $past(prescale_unity) && prescale_unity |-> bit_tick)
		else $error("unity prescale missed a bit tick");
	a_sixteen_m: assert property (
		bit_tick && $past(!prescale_unity && !prescale_enable) |-> $past(st_ff.pre_cnt) == 4'hF)
		else $error("default prescale not sixteen");

endmodule

// file: rtl/ubt_top.sv
/*
 * baud rate generator, transmit gap timer and receive idle time-out,
 * with an AHB-Lite register slave and two level interrupts, irq and rx_idle_irq.
 * assumes the receive queue and transmitter run on hclk and give
 * single-cycle strobes; the one AHB master drives hready from hreadyout.
 */
// Design decision made here: the AHB-Lite slave port.
`include "ubt_regs.svh"

module ubt_top
	import ubt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rx_word_push,
	input wire logic rx_queue_empty,
	input wire logic rx_buf_read,
	input wire logic tx_frame_done,
	output logic tx_start_ok,
	output logic baud_tick,
	output logic sample_tick,
	output logic rx_idle_irq,
	output logic rx_idle_flag,
	output logic ir_mode,
	output logic irq
);

	ubt_top_s st_ff;
	ubt_top_s nxt_st;
	logic [7:0] idle_cnt;
	logic [7:0] gap_cnt;
	logic [7:0] rx_idle_compare;
	logic [7:0] tx_gap_delay;
	logic idle_match;
	logic gap_inc;
	logic addr_ok;

	assign rx_idle_compare = st_ff.tor[`UBT_TOR_CMP];
	assign tx_gap_delay = st_ff.tor[`UBT_TOR_GAP];
	assign ir_mode = (st_ff.ctl[`UBT_CTL_FSEL] == `UBT_FSEL_IR);
	assign gap_inc = baud_tick && (st_ff.gap_st == ubt_gap_wait);
	// a match in the push cycle is stale: the counter restarts at that edge
	assign idle_match = !rx_queue_empty && !rx_word_push && (idle_cnt == rx_idle_compare);
	assign addr_ok = hsel && hready && htrans[1] && (hsize == `UBT_SIZE_WORD);

	// ==========================================================
	// baud generator
	ubt_baud_gen u_baud (
		.hclk(hclk),
		.hresetn(hresetn),
		.baud_divisor(st_ff.baud[`UBT_BAUD_DIV]),
		.prescale_value(st_ff.baud[`UBT_BAUD_X]),
		.prescale_enable(st_ff.baud[`UBT_BAUD_XEN]),
		.prescale_unity(st_ff.baud[`UBT_BAUD_ONE]),
		.ir_mode(ir_mode),
		.sample_tick(sample_tick),
		.bit_tick(baud_tick)
	);

	// ==========================================================
	// counters
	// idle counter restart
	ubt_tick_cnt #(.W(8)) u_idle_cnt (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(rx_word_push),
		.inc(baud_tick),
		.cnt(idle_cnt)
	);

	ubt_tick_cnt #(.W(8)) u_gap_cnt (
		.hclk(hclk),
		.hresetn(hresetn),
		.clr(tx_frame_done),
		.inc(gap_inc),
		.cnt(gap_cnt)
	);

	// ==========================================================
	// next state
	always_comb begin
		nxt_st = st_ff;

		// bus address phase capture
		if (hready) begin
			nxt_st.ph_act = addr_ok;
			nxt_st.ph_wr = hwrite;
			nxt_st.ph_addr = haddr[`UBT_ADDR_LSB];
		end

		case (st_ff.gap_st)
			ubt_gap_idle: begin
				if (tx_frame_done && (tx_gap_delay != 8'h00)) begin
					nxt_st.gap_st = ubt_gap_wait;
				end
			end
			ubt_gap_wait: begin
				if (tx_frame_done) begin
					nxt_st.gap_st = (tx_gap_delay != 8'h00) ? ubt_gap_wait : ubt_gap_idle;
				end else if (gap_cnt >= tx_gap_delay) begin
					nxt_st.gap_st = ubt_gap_idle;
					nxt_st.isr[`UBT_EVT_GAP] = 1'b1;
				end
			end
			default: begin
				nxt_st.gap_st = ubt_gap_idle;
			end
		endcase

		// register writes in the data phase
		if (st_ff.ph_act && st_ff.ph_wr) begin
			if (st_ff.ph_addr == `UBT_OFS_TOR) begin
				nxt_st.tor = hwdata & `UBT_MSK_TOR;
			end else if (st_ff.ph_addr == `UBT_OFS_BAUD) begin
				nxt_st.baud = hwdata & `UBT_MSK_BAUD;
			end else if (st_ff.ph_addr == `UBT_OFS_ISR) begin
				nxt_st.isr = nxt_st.isr & ~hwdata[1:0];
			end else if (st_ff.ph_addr == `UBT_OFS_IMR) begin
				nxt_st.imr = hwdata[1:0];
			end else if (st_ff.ph_addr == `UBT_OFS_CTL) begin
				nxt_st.ctl = hwdata & `UBT_MSK_CTL;
			end
		end

		// idle flag, set wins over a buffer read
		// push or empty drops the flag
		if (idle_match) begin
			nxt_st.idle_flag = 1'b1;
		end else if (rx_buf_read || rx_word_push || rx_queue_empty) begin
			nxt_st.idle_flag = 1'b0;
		end
		// a new time-out is logged after any w1c in the same cycle
		if (idle_match && !st_ff.idle_flag) begin
			nxt_st.isr[`UBT_EVT_IDLE] = 1'b1;
		end
		if (st_ff.gap_st == ubt_gap_wait && !tx_frame_done && gap_cnt >= tx_gap_delay) begin
			nxt_st.isr[`UBT_EVT_GAP] = 1'b1;
		end

		nxt_st.idle_irq = nxt_st.idle_flag && nxt_st.ctl[`UBT_CTL_IEN];
		nxt_st.irq = |(nxt_st.isr & nxt_st.imr);

		// read data from post-write values so back-to-back write then read agree
		if (addr_ok && !hwrite) begin
			if (haddr[`UBT_ADDR_LSB] == `UBT_OFS_TOR) begin
				nxt_st.hrdata = nxt_st.tor;
			end else if (haddr[`UBT_ADDR_LSB] == `UBT_OFS_BAUD) begin
				nxt_st.hrdata = nxt_st.baud;
			end else if (haddr[`UBT_ADDR_LSB] == `UBT_OFS_ISR) begin
				nxt_st.hrdata = {30'h00000000, nxt_st.isr};
			end else if (haddr[`UBT_ADDR_LSB] == `UBT_OFS_IMR) begin
				nxt_st.hrdata = {30'h00000000, nxt_st.imr};
			end else if (haddr[`UBT_ADDR_LSB] == `UBT_OFS_CTL) begin
				nxt_st.hrdata = nxt_st.ctl;
			end else begin
				nxt_st.hrdata = 32'h00000000;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff <= '0;
			st_ff.tor <= `UBT_RST_TOR;
			st_ff.baud <= `UBT_RST_BAUD;
			st_ff.ctl <= `UBT_RST_CTL;
			st_ff.gap_st <= ubt_gap_idle;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// outputs
	// zero wait states; every access completes OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = st_ff.hrdata;
	assign tx_start_ok = (st_ff.gap_st == ubt_gap_idle);
	assign rx_idle_irq = st_ff.idle_irq;
	assign rx_idle_flag = st_ff.idle_flag;
	assign irq = st_ff.irq;

	// ==========================================================
	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_idle_restart: assert property (
		rx_word_push |=> idle_cnt == 8'h00)
		else $error("idle counter not cleared by new word");
	a_idle_counts: assert property (
		baud_tick && !rx_word_push && idle_cnt != 8'hFF |=> idle_cnt == $past(idle_cnt) + 8'h01)
		else $error("idle counter missed a bit tick");
	a_idle_irq_set: assert property (
		idle_match && st_ff.ctl[`UBT_CTL_IEN] |=> rx_idle_irq)
		else $error("idle interrupt not raised on match");
	a_idle_irq_off: assert property (
		!st_ff.ctl[`UBT_CTL_IEN] |-> !rx_idle_irq)
		else $error("idle interrupt raised while disabled");
	a_irq_drop: assert property (
		rx_word_push || rx_queue_empty |=> !rx_idle_irq && !rx_idle_flag)
		else $error("idle interrupt held after push or empty");
	a_flag_read: assert property (
		rx_buf_read && !idle_match |=> !rx_idle_flag)
		else $error("idle flag not cleared by buffer read");
	a_gap_zero: assert property (
		tx_frame_done && tx_gap_delay == 8'h00 |=> tx_start_ok)
		else $error("zero gap delayed the next start");
	a_gap_hold: assert property (
		tx_frame_done && tx_gap_delay != 8'h00 |=> !tx_start_ok [*2])
		else $error("gap ended too early");
	a_gap_end: assert property (
		!tx_start_ok && gap_cnt >= tx_gap_delay && !tx_frame_done |=> tx_start_ok)
		else $error("gap did not end at count");
	a_ir_select: assert property (
		ir_mode |-> st_ff.ctl[9] && !st_ff.ctl[8])
		else $error("infrared mode decode wrong");
	a_irq_level: assert property (
		(|(st_ff.isr & st_ff.imr)) |-> irq)
		else $error("interrupt output low with pending unmasked status");
	a_irq_low: assert property (
		!(|(st_ff.isr & st_ff.imr)) |-> !irq)
		else $error("interrupt output high with nothing pending");

	// bus side: data phase writes land at its closing edge, reads answer from post-write state
	a_tor_write: assert property (
		st_ff.ph_act && st_ff.ph_wr && st_ff.ph_addr == `UBT_OFS_TOR
		|=> st_ff.tor == ($past(hwdata) & `UBT_MSK_TOR))
		else $error("time-out and gap register write lost");
	a_baud_write: assert property (
		st_ff.ph_act && st_ff.ph_wr && st_ff.ph_addr == `UBT_OFS_BAUD
		|=> st_ff.baud == ($past(hwdata) & `UBT_MSK_BAUD))
		else $error("baud divisor register write lost");
	a_ctl_write: assert property (
		st_ff.ph_act && st_ff.ph_wr && st_ff.ph_addr == `UBT_OFS_CTL
		|=> st_ff.ctl == ($past(hwdata) & `UBT_MSK_CTL))
		else $error("control register write lost");
	a_rd_tor: assert property (
		addr_ok && !hwrite && haddr[`UBT_ADDR_LSB] == `UBT_OFS_TOR |=> hrdata == st_ff.tor)
		else $error("time-out and gap register read wrong");
	a_rd_baud: assert property (
		addr_ok && !hwrite && haddr[`UBT_ADDR_LSB] == `UBT_OFS_BAUD |=> hrdata == st_ff.baud)
		else $error("baud divisor register read wrong");
	a_rd_unmapped: assert property (
		addr_ok && !hwrite && haddr[`UBT_ADDR_LSB] != `UBT_OFS_TOR
		&& haddr[`UBT_ADDR_LSB] != `UBT_OFS_BAUD && haddr[`UBT_ADDR_LSB] != `UBT_OFS_ISR
		&& haddr[`UBT_ADDR_LSB] != `UBT_OFS_IMR && haddr[`UBT_ADDR_LSB] != `UBT_OFS_CTL
		|=> hrdata == 32'h00000000)
		else $error("unmapped offset read not zero");
	a_rd_hold: assert property (
		!(addr_ok && !hwrite) |=> $stable(hrdata))
		else $error("read data changed without a read");
	a_flag_set: assert property (
		idle_match |=> rx_idle_flag)
		else $error("idle flag not set on match");
	a_flag_hold: assert property (
		rx_idle_flag && !rx_buf_read && !rx_word_push && !rx_queue_empty |=> rx_idle_flag)
		else $error("idle flag dropped without a clear");
	a_flag_quiet: assert property (
		!rx_idle_flag && !idle_match |=> !rx_idle_flag)
		else $error("idle flag set without a match");
	a_idle_status: assert property (
		idle_match && !rx_idle_flag |=> st_ff.isr[`UBT_EVT_IDLE])
		else $error("idle time-out status not logged");
	a_gap_restart: assert property (
		tx_frame_done |=> gap_cnt == 8'h00)
		else $error("gap counter not cleared by frame end");
	a_gap_count: assert property (
		gap_inc && !tx_frame_done && gap_cnt != 8'hFF |=> gap_cnt == $past(gap_cnt) + 8'h01)
		else $error("gap counter missed a bit tick");
	a_start_stays: assert property (
		tx_start_ok && !tx_frame_done |=> tx_start_ok)
		else $error("start withdrawn without a frame end");
	a_gap_status: assert property (
		!tx_start_ok && gap_cnt >= tx_gap_delay && !tx_frame_done |=> st_ff.isr[`UBT_EVT_GAP])
		else $error("gap finished status not logged");

endmodule

// file: testbench/ubt_far_end.sv
/*
 * far side model: remote line partner plus the receive queue it fills.
 * assumes the bench calls its tasks; outputs change just after hclk rises.
 */
module ubt_far_end
	import ubt_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tx_start_ok,
	output logic rx_word_push,
	output logic rx_queue_empty,
	output logic rx_buf_read,
	output logic tx_frame_done
);
	timeunit 1ns;
	timeprecision 100ps;
	int words;
	initial begin
		rx_word_push = 1'b0;
		rx_buf_read = 1'b0;
		tx_frame_done = 1'b0;
		words = 0;
	end
	assign rx_queue_empty = (words == 0);
	// ==========================================================
	// receive side
	task automatic push_word();
		@(posedge hclk);
		rx_word_push <= 1'b1;
		words <= words + 1;
		@(posedge hclk);
		rx_word_push <= 1'b0;
	endtask
	task automatic pop_word();
		@(posedge hclk);
		rx_buf_read <= 1'b1;
		words <= words - 1;
		@(posedge hclk);
		rx_buf_read <= 1'b0;
	endtask
	// ==========================================================
	// transmit side: a frame only ends once start was allowed
	task automatic end_frame();
		do @(posedge hclk); while (tx_start_ok !== 1'b1);
		tx_frame_done <= 1'b1;
		@(posedge hclk);
		tx_frame_done <= 1'b0;
	endtask
endmodule

// file: testbench/tb_top.sv
/*
 * self-checking bench for the baud and idle time-out block.
 * assumes a zero-wait AHB-Lite slave whose hreadyout is the bus hready.
 */
module tb_top
	import ubt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0] htrans;
	logic hreadyout, hresp, rx_word_push, rx_queue_empty, rx_buf_read, tx_frame_done;
	logic tx_start_ok, baud_tick, sample_tick, rx_idle_irq, rx_idle_flag, ir_mode, irq;
	int n_errors, total_checks, n;
	logic [31:0] cfg [4] = '{32'h0F000000, 32'h10000008, 32'h28000008, 32'h08000008};
	int per [4] = '{32, 10, 90, 160};
	int sp [4] = '{2, 10, 10, 10};

	always #2.5 hclk = ~hclk;

	ubt_top ubt_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.rx_word_push(rx_word_push), .rx_queue_empty(rx_queue_empty),
		.rx_buf_read(rx_buf_read), .tx_frame_done(tx_frame_done),
		.tx_start_ok(tx_start_ok), .baud_tick(baud_tick), .sample_tick(sample_tick),
		.rx_idle_irq(rx_idle_irq), .rx_idle_flag(rx_idle_flag), .ir_mode(ir_mode),
		.irq(irq));
	ubt_far_end ubt_far_end_i (.hclk(hclk), .hresetn(hresetn), .tx_start_ok(tx_start_ok),
		.rx_word_push(rx_word_push), .rx_queue_empty(rx_queue_empty),
		.rx_buf_read(rx_buf_read), .tx_frame_done(tx_frame_done));

	// ==========================================================
	// bus and compare tasks
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h000000, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int lo, input int hi);
		chk(32'(v), 32'((v < lo) ? lo : (v > hi) ? hi : v));
	endtask
	// counts edges until baud tick (0), idle irq (1), start allowed (2) or sample tick (3)
	task automatic until_hi(input int s, output int c);
		c = 0;
		do begin
			@(posedge hclk);
			c++;
		end while (!(s == 0 ? baud_tick === 1'b1 : s == 1 ? rx_idle_irq === 1'b1 :
			s == 2 ? tx_start_ok === 1'b1 : sample_tick === 1'b1) && c < 5000);
		// a wait that runs out is a mismatch on its own
		chk(32'(c < 5000), 32'h00000001);
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// watchdog: tests need well under 10000 cycles
	initial begin
		#(40000 * 5);
		n_errors++;
		close_out();
	end

	// ==========================================================
	// tests
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		n_errors = 0;
		total_checks = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 8'h20, 0); chk(q, 32'h00000000);
		bus(0, 8'h24, 0); chk(q, 32'h0F000000);
		bus(0, 8'h10, 0); chk(q, 32'h00000000);
		chk(hresp, 1'b0);
		bus(1, 8'h20, 32'hFFFFFFFF);
		bus(0, 8'h20, 0); chk(q, 32'h0000FFFF);
		$display("test registers done");
		// period table; reset value, then divisor 8 with unity, X=8 enabled, X=8 not enabled
		for (int i = 0; i < 4; i++) begin
			bus(1, 8'h24, cfg[i]);
			until_hi(0, n);
			until_hi(0, n);
			until_hi(0, n); chk(32'(n), 32'(per[i]));
			until_hi(3, n);
			until_hi(3, n); chk(32'(n), 32'(sp[i]));
		end
		bus(1, 8'h48, 32'h00000300);
		@(posedge hclk); chk(ir_mode, 1'b0);
		bus(1, 8'h48, 32'h00000200);
		@(posedge hclk); chk(ir_mode, 1'b1);
		bus(1, 8'h48, 32'h00000000);
		@(posedge hclk); chk(ir_mode, 1'b0);
		$display("test baud done");
		// compare 40, prescale clear so no infrared clash
		bus(1, 8'h24, 32'h10000008);
		bus(1, 8'h20, 32'h00000028);
		ubt_far_end_i.push_word();
		repeat (420) @(posedge hclk);
		chk(rx_idle_flag, 1'b1);
		chk(rx_idle_irq, 1'b0);
		ubt_far_end_i.pop_word();
		repeat (3) @(posedge hclk);
		chk(rx_idle_flag, 1'b0);
		bus(1, 8'h48, 32'h00000010);
		bus(1, 8'h44, 32'h00000001);
		bus(1, 8'h40, 32'h00000003);
		// align the push to a tick so the wait is exact
		until_hi(0, n);
		ubt_far_end_i.push_word();
		until_hi(1, n); rng(n, 396, 406);
		@(posedge hclk); chk(irq, 1'b1);
		bus(0, 8'h40, 0); chk(q, 32'h00000001);
		ubt_far_end_i.push_word();
		repeat (2) @(posedge hclk); chk(rx_idle_irq, 1'b0);
		until_hi(1, n);
		ubt_far_end_i.pop_word();
		ubt_far_end_i.pop_word();
		repeat (2) @(posedge hclk); chk(rx_idle_irq, 1'b0);
		chk(rx_idle_flag, 1'b0);
		bus(1, 8'h40, 32'h00000003);
		repeat (2) @(posedge hclk); chk(irq, 1'b0);
		bus(0, 8'h40, 0); chk(q, 32'h00000000);
		$display("test idle done");
		bus(1, 8'h44, 32'h00000002);
		bus(1, 8'h20, 32'h00000328);
		ubt_far_end_i.end_frame();
		@(posedge hclk); chk(tx_start_ok, 1'b0);
		until_hi(2, n); rng(n, 20, 32);
		repeat (2) @(posedge hclk); chk(irq, 1'b1);
		bus(0, 8'h40, 0); chk(q, 32'h00000002);
		bus(1, 8'h40, 32'h00000002);
		bus(1, 8'h20, 32'h00000028);
		ubt_far_end_i.end_frame();
		repeat (3) begin
			@(posedge hclk); chk(tx_start_ok, 1'b1);
		end
		$display("test gap done");
		close_out();
	end
endmodule
